// ---- rtl/wasr_pkg.sv ----
// Purpose: Constants and types for the waveform shutdown and restart block
// Assumes: AHB-Lite word registers, byte address is four times the index
// Notes:   Only the low eight data bits of each register are used
package wasr_pkg;
	// ==================================================================
	// Register indices
	localparam logic [13:0] IDX_CLOCK_SOURCE_SELECT    = 14'h0f3b;
	localparam logic [13:0] IDX_DATA_INPUT_SELECT      = 14'h0f3c;
	localparam logic [13:0] IDX_RISING_DEADBAND_COUNT  = 14'h0f3d;
	localparam logic [13:0] IDX_FALLING_DEADBAND_COUNT = 14'h0f3e;
	localparam logic [13:0] IDX_MAIN_CONTROL           = 14'h0f3f;
	localparam logic [13:0] IDX_POLARITY_AND_INPUT     = 14'h0f40;
	localparam logic [13:0] IDX_FAULT_CONTROL          = 14'h0f41;
	localparam logic [13:0] IDX_FAULT_SOURCE_ENABLES   = 14'h0f42;
	localparam logic [13:0] IDX_OUTPUT_STEERING        = 14'h0f43;

	// ==================================================================
	// Field positions
	localparam int POS_CS       = 0;
	localparam int POS_EN       = 7;
	localparam int POS_LOAD     = 6;
	localparam int POS_MODE     = 0;
	localparam int POS_IN       = 5;
	localparam int POS_POL      = 0;
	localparam int POS_SHUTDOWN = 7;
	localparam int POS_REN      = 6;
	localparam int POS_BD_LEVEL = 4;
	localparam int POS_AC_LEVEL = 2;
	localparam int POS_STR      = 0;
	localparam int POS_OVR      = 4;

	// ==================================================================
	// Reset values and encodings
	localparam logic [1:0] RST_OVERRIDE_LEVEL = 2'h1;
	localparam logic [1:0] LVL_HIGH           = 2'h3;
	localparam logic [1:0] LVL_LOW            = 2'h2;
	localparam logic [1:0] LVL_FLOAT          = 2'h1;
	// Fault inputs whose active level is high (three timer sources)
	localparam logic [7:0] FAULT_ACTIVE_HIGH  = 8'h0e;
	localparam logic [1:0] HTRANS_NONSEQ      = 2'h2;
	localparam logic       HRESP_OKAY         = 1'b0;

	// ==================================================================
	// Output sequencing states
	typedef enum logic [1:0] {
		ST_OFF,
		ST_SHUT,
		ST_WAIT,
		ST_RUN
	} wasr_state_t;
endpackage : wasr_pkg

// ---- rtl/wasr_top.sv ----
// Purpose: Shutdown, override and restart logic of a four-output waveform unit
// Assumes: All inputs synchronous to clk; single AHB-Lite slave, zero wait states
// Notes:   Dead-band timing is not modelled; counts are stored and read back
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
module wasr_top
	import wasr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [15:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [15:0] data_sources,
	input  wire logic        data_src_alive,
	input  wire logic [7:0]  fault_in,
	output logic      [3:0]  out_level,
	output logic      [3:0]  out_oe,
	output logic             unit_irq_flag,
	output logic             keep_fast_osc
);
	// ==================================================================
	// Register state
	logic        clk_sel;
	logic [3:0]  data_source_field;
	logic [5:0]  rising_dead_count;
	logic [5:0]  falling_dead_count;
	logic        en;
	logic        deadband_load_bit;
	logic [2:0]  mode;
	logic [3:0]  output_polarity_bits;
	logic        sd;
	logic        ren;
	logic [1:0]  bd_override_level;
	logic [1:0]  ac_override_level;
	logic [7:0]  fault_source_enable;
	logic [3:0]  steer_enable_bits;
	logic [3:0]  steer_level_bits;
	wasr_state_t state;
	wasr_state_t next_state;
	logic        data_q;

	// ==================================================================
	// Bus address and data phase
	logic        dp_write;
	logic [13:0] dp_idx;
	wire         ap_take  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
	wire         ap_align = (haddr[1:0] == 2'h0);
	wire [13:0]  ap_idx   = haddr[15:2];
	wire [7:0]   wdata    = hwdata[7:0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dp_write <= 1'b0;
			dp_idx   <= 14'h0000;
		end else begin
			dp_write <= ap_take && hwrite && ap_align;
			dp_idx   <= ap_idx;
		end
	end

	wire wr_clk  = dp_write && (dp_idx == IDX_CLOCK_SOURCE_SELECT);
	wire wr_dsel = dp_write && (dp_idx == IDX_DATA_INPUT_SELECT);
	wire wr_dbr  = dp_write && (dp_idx == IDX_RISING_DEADBAND_COUNT);
	wire wr_dbf  = dp_write && (dp_idx == IDX_FALLING_DEADBAND_COUNT);
	wire wr_main = dp_write && (dp_idx == IDX_MAIN_CONTROL);
	wire wr_pol  = dp_write && (dp_idx == IDX_POLARITY_AND_INPUT);
	wire wr_fc   = dp_write && (dp_idx == IDX_FAULT_CONTROL);
	wire wr_fse  = dp_write && (dp_idx == IDX_FAULT_SOURCE_ENABLES);
	wire wr_str  = dp_write && (dp_idx == IDX_OUTPUT_STEERING);

	// ==================================================================
	// Data input selection and edge
	wire data_sel  = data_sources[data_source_field];
	wire data_rise = data_sel && !data_q;

	// ==================================================================
	// Fault detection
	// fault level mapping
	wire [7:0] fault_level  = fault_in ^ ~FAULT_ACTIVE_HIGH;
	wire [7:0] fault_active = fault_level & fault_source_enable;
	wire       any_fault    = |fault_active;

	// ==================================================================
	// Shutdown status bit
	wire next_en   = wr_main ? wdata[POS_EN] : en;
	wire start_set = wr_main && wdata[POS_EN] && !en;
	wire hw_set    = en && any_fault;
	wire sw_set    = wr_fc && wdata[POS_SHUTDOWN];
	wire sw_clr    = wr_fc && !wdata[POS_SHUTDOWN] && !any_fault;
	wire auto_clr  = ren && sd && !any_fault;
	wire sd_set    = hw_set || sw_set || start_set;
	wire next_sd   = sd_set ? 1'b1 : ((sw_clr || auto_clr) ? 1'b0 : sd);
	wire shut_now  = next_en && next_sd;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sd <= 1'b0;
		end else begin
			sd <= next_sd;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			unit_irq_flag <= 1'b0;
		end else begin
			unit_irq_flag <= next_sd && !sd;
		end
	end

	// ==================================================================
	// Control registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_sel            <= 1'b0;
			data_source_field  <= 4'h0;
			rising_dead_count  <= 6'h00;
			falling_dead_count <= 6'h00;
			en                 <= 1'b0;
			mode               <= 3'h0;
		end else begin
			if (wr_clk) clk_sel <= wdata[POS_CS];
			if (wr_dsel) data_source_field <= wdata[3:0];
			if (wr_dbr) rising_dead_count <= wdata[5:0];
			if (wr_dbf) falling_dead_count <= wdata[5:0];
			en <= next_en;
			if (wr_main) mode <= wdata[POS_MODE +: 3];
		end
	end

	// Load request only sticks once the unit is already on
	wire next_ld = wr_main ? (wdata[POS_LOAD] && en) : (deadband_load_bit && !data_rise);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			deadband_load_bit    <= 1'b0;
			output_polarity_bits <= 4'h0;
			ren                  <= 1'b0;
			bd_override_level    <= RST_OVERRIDE_LEVEL;
			ac_override_level    <= RST_OVERRIDE_LEVEL;
			fault_source_enable  <= 8'h00;
			steer_enable_bits    <= 4'h0;
			steer_level_bits     <= 4'h0;
		end else begin
			deadband_load_bit <= next_ld;
			if (wr_pol) output_polarity_bits <= wdata[POS_POL +: 4];
			if (wr_fc) begin
				ren               <= wdata[POS_REN];
				bd_override_level <= wdata[POS_BD_LEVEL +: 2];
				ac_override_level <= wdata[POS_AC_LEVEL +: 2];
			end
			if (wr_fse) fault_source_enable <= wdata;
			if (wr_str) begin
				steer_enable_bits <= wdata[POS_STR +: 4];
				steer_level_bits  <= wdata[POS_OVR +: 4];
			end
		end
	end

	// ==================================================================
	// Read data, sampled in the address phase
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (ap_idx == IDX_CLOCK_SOURCE_SELECT) begin
			rd_byte = {7'h00, clk_sel};
		end else if (ap_idx == IDX_DATA_INPUT_SELECT) begin
			rd_byte = {4'h0, data_source_field};
		end else if (ap_idx == IDX_RISING_DEADBAND_COUNT) begin
			rd_byte = {2'h0, rising_dead_count};
		end else if (ap_idx == IDX_FALLING_DEADBAND_COUNT) begin
			rd_byte = {2'h0, falling_dead_count};
		end else if (ap_idx == IDX_MAIN_CONTROL) begin
			rd_byte = {en, deadband_load_bit, 3'h0, mode};
		end else if (ap_idx == IDX_POLARITY_AND_INPUT) begin
			rd_byte = {2'h0, data_sel, 1'b0, output_polarity_bits};
		end else if (ap_idx == IDX_FAULT_CONTROL) begin
			rd_byte = {sd, ren, bd_override_level, ac_override_level, 2'h0};
		end else if (ap_idx == IDX_FAULT_SOURCE_ENABLES) begin
			rd_byte = fault_source_enable;
		end else if (ap_idx == IDX_OUTPUT_STEERING) begin
			rd_byte = {steer_level_bits, steer_enable_bits};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end else begin
			if (ap_take && !hwrite) hrdata <= (ap_align ? {24'h00_0000, rd_byte} : 32'h0000_0000);
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end
	end

	// ==================================================================
	// Output sequencing
	always_comb begin
		next_state = state;
		if (!next_en) begin
			next_state = ST_OFF;
		end else if (shut_now) begin
			next_state = ST_SHUT;
		end else begin
			case (state)
				ST_OFF:  next_state = ST_WAIT;
				ST_SHUT: next_state = ST_WAIT;
				ST_WAIT: next_state = data_rise ? ST_RUN : ST_WAIT;
				ST_RUN:  next_state = ST_RUN;
				default: next_state = ST_OFF;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state  <= ST_OFF;
			data_q <= 1'b0;
		end else begin
			state  <= next_state;
			data_q <= data_sel;
		end
	end

	// ==================================================================
	// Per output level and enable
	logic [3:0] next_level;
	logic [3:0] next_oe;
	logic [3:0] ovr_level;
	logic [3:0] ovr_oe;
	logic [3:0] wave;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_out
			wire [1:0] fld = (g % 2 == 1) ? bd_override_level : ac_override_level;
			assign ovr_level[g] = (fld == LVL_HIGH) ? 1'b1 :
				((fld == LVL_LOW || fld == LVL_FLOAT) ? 1'b0 : output_polarity_bits[g]);
			assign ovr_oe[g]    = (fld != LVL_FLOAT);
			wire norm = ((g % 2 == 1) ? !data_sel : data_sel) ^ output_polarity_bits[g];
			wire stv  = steer_enable_bits[g] ? (data_sel ^ output_polarity_bits[g])
				: steer_level_bits[g];
			assign wave[g] = (mode[2:1] == 2'h0) ? stv : norm;
		end
	endgenerate

	always_comb begin
		next_level = 4'h0;
		next_oe    = 4'h0;
		case (next_state)
			ST_SHUT: begin
				next_level = ovr_level;
				next_oe    = ovr_oe;
			end
			ST_WAIT: begin
				next_level = ovr_level;
				next_oe    = ovr_oe;
			end
			ST_RUN: begin
				next_level = wave;
				next_oe    = 4'hf;
			end
			default: begin
				next_level = 4'h0;
				next_oe    = 4'h0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_level     <= 4'h0;
			out_oe        <= 4'h0;
			keep_fast_osc <= 1'b0;
		end else begin
			out_level     <= next_level;
			out_oe        <= next_oe;
			keep_fast_osc <= next_en && clk_sel && data_src_alive;
		end
	end

	// ==================================================================
	// Checks
	property p_sw_set;
		@(posedge clk) disable iff (!rst_n)
		wr_fc && wdata[POS_SHUTDOWN] |=> sd && unit_irq_flag == !$past(sd);
	endproperty
	a_sw_set: assert property (p_sw_set) else $error("software set missed");

	property p_fault_set;
		@(posedge clk) disable iff (!rst_n)
		en && any_fault |=> sd;
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault did not set");

	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		!ren && sd && !(wr_fc && !wdata[POS_SHUTDOWN]) |=> sd;
	endproperty
	a_hold: assert property (p_hold) else $error("shutdown dropped");

	property p_auto_clr;
		@(posedge clk) disable iff (!rst_n)
		ren && sd && !any_fault && !sw_set && !start_set && !hw_set |=> !sd;
	endproperty
	a_auto_clr: assert property (p_auto_clr) else $error("auto clear missed");

	property p_override;
		@(posedge clk) disable iff (!rst_n)
		en && any_fault && !(wr_main && !wdata[POS_EN])
		|=> out_level == $past(ovr_level) && out_oe == $past(ovr_oe);
	endproperty
	a_override: assert property (p_override) else $error("override late");

	property p_level_hold;
		@(posedge clk) disable iff (!rst_n)
		(sd && any_fault) ##1 any_fault |-> sd [*2];
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("fault level lost");

	property p_float;
		@(posedge clk) disable iff (!rst_n)
		shut_now && bd_override_level == LVL_FLOAT |=> !out_oe[1] && !out_oe[3];
	endproperty
	a_float: assert property (p_float) else $error("float code wrong");

	property p_irq;
		@(posedge clk) disable iff (!rst_n)
		unit_irq_flag |-> sd && !$past(sd);
	endproperty
	a_irq: assert property (p_irq) else $error("stray interrupt");

	property p_no_clr;
		@(posedge clk) disable iff (!rst_n)
		wr_fc && !wdata[POS_SHUTDOWN] && en && any_fault |=> sd;
	endproperty
	a_no_clr: assert property (p_no_clr) else $error("clear not ignored");

	property p_start;
		@(posedge clk) disable iff (!rst_n)
		$rose(en) |-> sd && state == ST_SHUT;
	endproperty
	a_start: assert property (p_start) else $error("not started shut");

	property p_wait_edge;
		@(posedge clk) disable iff (!rst_n)
		state == ST_WAIT && next_en && !shut_now && !data_rise |=> state == ST_WAIT;
	endproperty
	a_wait_edge: assert property (p_wait_edge) else $error("resumed early");
endmodule : wasr_top

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the shutdown and restart block
// Assumes: Zero wait state slave, but every wait is bounded
// Notes:   Half-bridge then steering mode, overrides B/D low and A/C high
`timescale 1ns/1ps
module tb
	import wasr_pkg::*;
;
	// ==================================================================
	// Signals
	localparam logic [15:0] A_CTL = {IDX_MAIN_CONTROL, 2'b00};
	localparam logic [15:0] A_FLT = {IDX_FAULT_CONTROL, 2'b00};
	localparam logic [15:0] A_ENA = {IDX_FAULT_SOURCE_ENABLES, 2'b00};
	localparam logic [15:0] A_CLK = {IDX_CLOCK_SOURCE_SELECT, 2'b00};
	localparam logic [15:0] A_POL = {IDX_POLARITY_AND_INPUT, 2'b00};
	localparam logic [15:0] A_SEL = {IDX_DATA_INPUT_SELECT, 2'b00};
	localparam logic [15:0] A_STR = {IDX_OUTPUT_STEERING, 2'b00};
	localparam logic [3:0]  OV    = 4'h5;
	logic        clk;
	logic        rst_n;
	logic        hsel;
	logic        hwrite;
	logic [15:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [15:0] data_sources;
	logic        alive;
	logic        dbit;
	logic [7:0]  fact;
	logic [7:0]  fault_in;
	logic [3:0]  out_level;
	logic [3:0]  out_oe;
	logic        irq;
	logic        kfo;
	int          mismatches = 0;
	int          tests_run  = 0;
	int          irq_cnt    = 0;

	wasr_top dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .data_sources(data_sources),
		.data_src_alive(alive), .fault_in(fault_in), .out_level(out_level),
		.out_oe(out_oe), .unit_irq_flag(irq), .keep_fast_osc(kfo));
	wasr_far far_u (.fault_act(fact), .data_bit(dbit), .fault_in(fault_in),
		.data_sources(data_sources));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Pulses are one cycle wide, so count them as they pass
	always @(posedge clk) begin
		if (irq === 1'b1) begin
			irq_cnt <= irq_cnt + 1;
		end
	end

	// ==================================================================
	// Tasks
	task give_verdict;
		if (mismatches == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", nm, exp, got);
			mismatches++;
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			mismatches++;
			give_verdict();
		end
	endtask : wait_rdy

	task bus(input logic [15:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
		chk("hresp", {31'h0000_0000, HRESP_OKAY}, {31'h0000_0000, hresp});
	endtask : bus

	task wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask : wr

	task rd(input string nm, input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(a, 1'b0, 32'h0000_0000, r);
		chk(nm, exp, r);
	endtask : rd

	task outs(input logic [3:0] lv, input logic [3:0] oe);
		chk("out_oe", oe, out_oe);
		chk("out_level", lv & oe, out_level & oe);
	endtask : outs

	// Data rises, then falls, so a stuck override cannot pass
	task wave(input logic [3:0] lv);
		dbit <= 1'b1;
		cyc(3);
		dbit <= 1'b0;
		cyc(3);
		outs(lv, 4'hf);
	endtask : wave

	// ==================================================================
	// Sequence
	initial begin
		rst_n  = 1'b0;
		hsel   = 1'b0;
		haddr  = 16'h0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0000_0000;
		alive  = 1'b0;
		dbit   = 1'b0;
		fact   = 8'h00;
		cyc(10);
		rst_n <= 1'b1;
		cyc(1);
		rd("fault_control", A_FLT, 32'h0000_0014);
		rd("unmapped", 16'h0000, 32'h0000_0000);
		wr(A_CTL, 32'h0000_0004);
		wr(A_FLT, 32'h0000_002c);
		wr(A_CLK, 32'h0000_0001);
		outs(4'h0, 4'h0);
		alive <= 1'b1;
		wr(A_CTL, 32'h0000_0084);
		cyc(2);
		rd("enable start", A_FLT, 32'h0000_00ac);
		outs(OV, 4'hf);
		chk("irq count", 1, irq_cnt);
		chk("keep osc", 1, kfo);
		alive <= 1'b0;
		cyc(2);
		chk("keep osc", 0, kfo);
		alive <= 1'b1;
		wr(A_FLT, 32'h0000_002c);
		rd("sw clear", A_FLT, 32'h0000_002c);
		cyc(2);
		outs(OV, 4'hf);
		wave(4'ha);
		for (int c = 0; c < 4; c++) begin
			wr(A_FLT, 32'h80 | (c << 4) | (c << 2));
			cyc(2);
			outs({4{c == 3}}, c == 1 ? 4'h0 : 4'hf);
		end
		wr(A_FLT, 32'h0000_002c);
		wave(4'ha);
		for (int i = 0; i < 8; i++) begin
			wr(A_ENA, 32'h1 << i);
			fact <= ~(8'h01 << i);
			cyc(3);
			rd("other source", A_FLT, 32'h0000_002c);
			fact <= 8'h01 << i;
			cyc(3);
			outs(OV, 4'hf);
			rd("fault set", A_FLT, 32'h0000_00ac);
			wr(A_FLT, 32'h0000_002c);
			rd("clear refused", A_FLT, 32'h0000_00ac);
			fact <= 8'h00;
			cyc(3);
			rd("held", A_FLT, 32'h0000_00ac);
			wr(A_FLT, 32'h0000_002c);
			rd("released", A_FLT, 32'h0000_002c);
		end
		fact <= 8'h10;
		wr(A_ENA, 32'h0000_0010);
		cyc(3);
		wr(A_ENA, 32'h0000_0000);
		wr(A_FLT, 32'h0000_002c);
		rd("disabled source", A_FLT, 32'h0000_002c);
		fact <= 8'h00;
		wr(A_FLT, 32'h0000_006c);
		wr(A_ENA, 32'h0000_0002);
		fact <= 8'h02;
		cyc(3);
		rd("auto held", A_FLT, 32'h0000_00ec);
		fact <= 8'h00;
		cyc(3);
		rd("auto clear", A_FLT, 32'h0000_006c);
		outs(OV, 4'hf);
		wave(4'ha);
		wr(A_CTL, 32'h0000_0000);
		cyc(2);
		outs(4'h0, 4'h0);
		wr(A_POL, 32'h0000_0001);
		wr(A_SEL, 32'h0000_0001);
		wr(A_STR, 32'h0000_0025);
		rd("steering", A_STR, 32'h0000_0025);
		wr(A_CTL, 32'h0000_0080);
		wr(A_CTL, 32'h0000_00c0);
		rd("load set", A_CTL, 32'h0000_00c0);
		rd("input level", A_POL, 32'h0000_0021);
		wave(4'h6);
		rd("load cleared", A_CTL, 32'h0000_0080);
		chk("irq count", 13, irq_cnt);
		give_verdict();
	end
endmodule : tb

// ---- sim/wasr_far.sv ----
// Purpose: Far-side model of the fault sources and data sources
// Assumes: Requests change just after a rising clock edge
// Notes:   Idle sources sit at their inactive level
`timescale 1ns/1ps
module wasr_far (
	input  wire logic [7:0]  fault_act,
	input  wire logic        data_bit,
	output logic      [7:0]  fault_in,
	output logic      [15:0] data_sources
);
	// ==================================================================
	// Sources
	// mixed active levels
	assign fault_in     = ~(fault_act ^ 8'h0e);
	// Inputs 1 to 15 carry the inverse of input 0, so a wrong select shows up
	assign data_sources = {~{15{data_bit}}, data_bit};
endmodule : wasr_far
